// [shared/cbcr_pkg.sv]
// Package for the clock buffer configuration register bank.
// Assumes a 16-bit word per location, reached over APB at byte address 4 * index.
package cbcr_pkg;

   // Geometry of the bank
   localparam int CBCR_WORD_W = 16;
   localparam int CBCR_SLOTS = 20;
   localparam int CBCR_INDEX_W = 7;
   localparam int CBCR_ADDR_W = 12;
   localparam int CBCR_DATA_W = 32;
   localparam int CBCR_LEVEL_W = 3;
   localparam int CBCR_OUTS = 4;
   localparam int CBCR_SLOT_W = 5;
   localparam int CBCR_BYTE_LSB = 2;

   // Printed offsets, kept as word indices
   localparam logic [6:0] IDX_POWER_CONTROL = 7'h00;
   localparam logic [6:0] IDX_SEQ_CLOCK_CTRL = 7'h02;
   localparam logic [6:0] IDX_OUTPUT_ENABLES = 7'h03;
   localparam logic [6:0] IDX_LEVEL_LOW_PAIR = 7'h04;
   localparam logic [6:0] IDX_LEVEL_HIGH_PAIR = 7'h05;
   localparam logic [6:0] IDX_AUX_OUTPUT_CONFIG = 7'h07;
   localparam logic [6:0] IDX_AUX_PREDIV_CTRL = 7'h08;
   localparam logic [6:0] IDX_SYNC_AUX_DIV_CTRL = 7'h09;
   localparam logic [6:0] IDX_POSITION_CAPTURE_LOW = 7'h0B;
   localparam logic [6:0] IDX_POSITION_CAPTURE_HIGH = 7'h0C;
   localparam logic [6:0] IDX_SYNC_DELAY_STEP = 7'h0D;
   localparam logic [6:0] IDX_SYNC_CAPTURE_CTRL = 7'h0E;
   localparam logic [6:0] IDX_SYNC_DELAY_CLEAR = 7'h0F;
   localparam logic [6:0] IDX_MUXOUT_SENSOR_CTRL = 7'h17;
   localparam logic [6:0] IDX_SENSOR_READBACK = 7'h18;
   localparam logic [6:0] IDX_MAIN_DIVIDER_CTRL = 7'h19;
   localparam logic [6:0] IDX_PIN_SETTING_READBACK = 7'h4B;
   localparam logic [6:0] IDX_AUX_BYPASS_SETUP_A = 7'h4F;
   localparam logic [6:0] IDX_MUXOUT_OVERRIDE_CTRL = 7'h56;
   localparam logic [6:0] IDX_AUX_BYPASS_SETUP_B = 7'h5A;

   // Slot table, slot n holds the location at cbcr_index[n]
   localparam logic [6:0] cbcr_index [CBCR_SLOTS] = '{
      IDX_POWER_CONTROL, IDX_SEQ_CLOCK_CTRL, IDX_OUTPUT_ENABLES, IDX_LEVEL_LOW_PAIR,
      IDX_LEVEL_HIGH_PAIR, IDX_AUX_OUTPUT_CONFIG, IDX_AUX_PREDIV_CTRL, IDX_SYNC_AUX_DIV_CTRL,
      IDX_POSITION_CAPTURE_LOW, IDX_POSITION_CAPTURE_HIGH, IDX_SYNC_DELAY_STEP,
      IDX_SYNC_CAPTURE_CTRL, IDX_SYNC_DELAY_CLEAR, IDX_MUXOUT_SENSOR_CTRL,
      IDX_SENSOR_READBACK, IDX_MAIN_DIVIDER_CTRL, IDX_PIN_SETTING_READBACK,
      IDX_AUX_BYPASS_SETUP_A, IDX_MUXOUT_OVERRIDE_CTRL, IDX_AUX_BYPASS_SETUP_B};

   // Slots of the words the block's own logic uses
   localparam logic [4:0] SLOT_POWER = 5'h00;
   localparam logic [4:0] SLOT_SEQ_CLOCK = 5'h01;
   localparam logic [4:0] SLOT_ENABLES = 5'h02;
   localparam logic [4:0] SLOT_LEVEL_LOW = 5'h03;
   localparam logic [4:0] SLOT_LEVEL_HIGH = 5'h04;
   localparam logic [4:0] SLOT_CAPTURE_LOW = 5'h08;
   localparam logic [4:0] SLOT_CAPTURE_HIGH = 5'h09;

   // Reset values; locations without a known value start at zero
   localparam logic [15:0] cbcr_reset [CBCR_SLOTS] = '{
      16'h0000, 16'h0223, 16'hF0FE, 16'h36FF, 16'h36F6, 16'h543F, 16'h0120, 16'h0020,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000};

   // Writable bits; zero bits are read-only and keep their reset value
   localparam logic [15:0] cbcr_wmask [CBCR_SLOTS] = '{
      16'h0007, 16'h07FF, 16'hFFFF, 16'h3FFF, 16'h7FFF, 16'h7FFF, 16'h01FF, 16'hFFFF,
      16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};

   // Field positions
   localparam int LOW_POWER_BIT = 2;
   localparam int SEQ_CLOCK_BIT = 5;
   localparam int HF_ON_LSB = 12;
   localparam int HF_OUT0_LEVEL_LSB = 8;
   localparam int HF_OUT1_LEVEL_LSB = 11;
   localparam int HF_OUT2_LEVEL_LSB = 0;
   localparam int HF_OUT3_LEVEL_LSB = 3;

   // Control fields presented to the clock path
   typedef struct packed {
      logic low_power_request;
      logic seq_clock_gen_on;
      logic [3:0] hf_on;
      logic [3:0] hf_active;
      logic [3:0][2:0] hf_level;
   } cbcr_ctrl_type;

   // Result of an address decode
   typedef struct packed {
      logic hit;
      logic [4:0] slot;
   } cbcr_decode_type;

endpackage

// [src/cbcr_reg_word.sv]
// One 16-bit configuration word with a per-bit write mask.
// Assumes the caller qualifies write_en with a completed bus write.
`timescale 1ns/1ps

module cbcr_reg_word #(
   parameter logic [15:0] RESET_VALUE = 16'h0000,
   parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Write port
   input wire logic write_en,
   input wire logic [15:0] write_data,
   // Stored word
   output logic [15:0] value
);

   // Masked update; read-only bits never leave their reset value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value <= RESET_VALUE;
      end else if (write_en) begin
         value <= (value & ~WRITE_MASK) | (write_data & WRITE_MASK);
      end
   end

endmodule

// [src/cbcr_regs.sv]
// APB register bank for a four-output clock buffer and divider.
// Assumes an APB master on pclk; the capture word comes from the sync logic synchronously.
`timescale 1ns/1ps

// Behaviour
// - Decode exactly the twenty listed word locations; all else is unmapped.
// - Power word bit 2 puts the device in low power, contents kept.
// - Power word resets to zero; host writes zero to other bits.
// - Sequencer clock enable resets set; host initialises with it set.
// - Sequencer word resets to 0x0223; host writes its fixed fields.
// - Enable word bits 15..12 enable outputs three..zero; reset 0xF0FE.
// - Low level pair: bits 13..11 output one, 10..8 output zero, reset 6.
// - Low level pair resets to 0x36FF; host writes fixed low byte.
// - High level pair: bits 5..3 output three, 2..0 output two, reset 6.
// - High level pair resets to 0x36F6; host writes fixed fields.
// - Read-only reserved bits read as their reset value and ignore writes.
module cbcr_regs
   import cbcr_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CBCR_ADDR_W-1:0] paddr,
   input wire logic [CBCR_DATA_W-1:0] pwdata,
   output logic [CBCR_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Position capture from the sync logic
   input wire logic [31:0] capture_position,
   // Controls to the clock path
   output cbcr_ctrl_type ctrl
);

   // Map a byte address onto a slot of the bank
   function automatic cbcr_decode_type decode_addr(input logic [CBCR_ADDR_W-1:0] addr);
      cbcr_decode_type result;
      result = '0;
      // Sub-word byte addresses are not locations at all
      if (addr[CBCR_BYTE_LSB-1:0] == 2'h0) begin
         for (int i = 0; i < CBCR_SLOTS; i++) begin
            if (addr[CBCR_ADDR_W-1:CBCR_BYTE_LSB] == {3'h0, cbcr_index[i]}) begin
               result.hit = 1'b1;
               result.slot = CBCR_SLOT_W'(i);
            end
         end
      end
      return result;
   endfunction

   // Stored words of every slot
   logic [CBCR_WORD_W-1:0] word [CBCR_SLOTS];

   // Decode of the current request
   cbcr_decode_type req_decode;

   // Bus phase qualifiers
   logic setup_phase;
   logic access_phase;
   logic write_fire;

   // Read data selected for the current request
   logic [CBCR_WORD_W-1:0] next_read_word;

   // Word held between the setup and access phases
   logic [CBCR_WORD_W-1:0] read_word;

   // Per-slot write strobes
   logic [CBCR_SLOTS-1:0] slot_write;

   // Decoded field views of the control words
   logic low_power;
   logic seq_clock_on;
   logic [CBCR_OUTS-1:0] hf_on;
   logic [CBCR_OUTS-1:0][CBCR_LEVEL_W-1:0] hf_level;

   // Phases of the transfer
   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;

   // The address is decoded in both phases; the master holds it stable
   assign req_decode = decode_addr(paddr);

   // A write lands only on a mapped location at the access edge
   assign write_fire = access_phase & pwrite & req_decode.hit;

   // Zero wait states: the bank answers every access in its first access cycle.
   // The read word is captured in setup so that prdata leaves a flip-flop.
   assign pready = 1'b1;

   // Unmapped locations answer with an error; no stored word changes for them
   assign pslverr = access_phase & ~req_decode.hit;

   // One strobe per slot from the shared decode
   generate
      for (genvar s = 0; s < CBCR_SLOTS; s++) begin : g_strobe
         assign slot_write[s] = write_fire & (req_decode.slot == CBCR_SLOT_W'(s));
      end
   endgenerate

   // One storage word per slot; writable bits follow the table masks
   generate
      for (genvar s = 0; s < CBCR_SLOTS; s++) begin : g_word
         cbcr_reg_word #(
            .RESET_VALUE(cbcr_reset[s]),
            .WRITE_MASK(cbcr_wmask[s])
         ) u_word (
            .pclk(pclk),
            .presetn(presetn),
            .write_en(slot_write[s]),
            .write_data(pwdata[CBCR_WORD_W-1:0]),
            .value(word[s])
         );
      end
   endgenerate

   // Read selection; capture words show the sync logic, not stored bits
   always_comb begin
      next_read_word = '0;
      if (req_decode.hit) begin
         unique case (req_decode.slot)
            SLOT_CAPTURE_LOW: begin
               next_read_word = capture_position[CBCR_WORD_W-1:0];
            end
            SLOT_CAPTURE_HIGH: begin
               next_read_word = capture_position[2*CBCR_WORD_W-1:CBCR_WORD_W];
            end
            default: begin
               // Slot codes above the table cannot decode as a hit
               next_read_word = word[req_decode.slot];
            end
         endcase
      end
   end

   // Read word is sampled in the setup cycle and held through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_word <= '0;
      end else if (setup_phase & ~pwrite) begin
         read_word <= next_read_word;
      end
   end

   // Upper half of the bus word is always zero
   assign prdata = {{(CBCR_DATA_W-CBCR_WORD_W){1'b0}}, read_word};

   // Power word: only the low-power request drives logic
   assign low_power = word[SLOT_POWER][LOW_POWER_BIT];

   // Sequencer clock generator enable, set from reset
   assign seq_clock_on = word[SLOT_SEQ_CLOCK][SEQ_CLOCK_BIT];

   // Output enables, output zero in the lowest of the four bits
   assign hf_on = word[SLOT_ENABLES][HF_ON_LSB +: CBCR_OUTS];

   // Drive levels of outputs zero and one
   assign hf_level[0] = word[SLOT_LEVEL_LOW][HF_OUT0_LEVEL_LSB +: CBCR_LEVEL_W];
   assign hf_level[1] = word[SLOT_LEVEL_LOW][HF_OUT1_LEVEL_LSB +: CBCR_LEVEL_W];

   // Drive levels of outputs two and three
   assign hf_level[2] = word[SLOT_LEVEL_HIGH][HF_OUT2_LEVEL_LSB +: CBCR_LEVEL_W];
   assign hf_level[3] = word[SLOT_LEVEL_HIGH][HF_OUT3_LEVEL_LSB +: CBCR_LEVEL_W];

   // Control bundle; the stored words are flops, so a write shows one edge later
   always_comb begin
      ctrl.low_power_request = low_power;
      // Low power stops the sequencer clock but its enable bit is kept
      ctrl.seq_clock_gen_on = seq_clock_on & ~low_power;
      ctrl.hf_on = hf_on;
      // Active outputs: enabled and not parked in low power
      ctrl.hf_active = hf_on & {CBCR_OUTS{~low_power}};
      ctrl.hf_level = hf_level;
   end

endmodule

// [test/cbcr_host.sv]
// Host model: an APB master that writes and reads configuration words.
// Assumes the slave samples on the rising edge of pclk; the bench owns reset.
`timescale 1ns/1ps
module cbcr_host (
   // Clock
   input wire logic pclk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // One transfer; write data is scrambled after release so stale data cannot pass
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~pwdata;
   endtask
   // Start-up writes with the fixed fields; sequencer clock kept on for pin modes
   task automatic init();
      logic [31:0] rd;
      logic err;
      xfer(1'b1, 12'h000, 16'h0000, rd, err);
      xfer(1'b1, 12'h008, 16'h0223, rd, err);
      xfer(1'b1, 12'h00C, 16'hF0FE, rd, err);
      xfer(1'b1, 12'h010, 16'h36FF, rd, err);
      xfer(1'b1, 12'h014, 16'h36F6, rd, err);
   endtask
endmodule

// [test/cbcr_properties.sv]
// Checker for the configuration register bank, watching only the top ports.
// Assumes one clock domain, pclk, with presetn asynchronous and active low.
`timescale 1ns/1ps
module cbcr_properties
   import cbcr_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CBCR_ADDR_W-1:0] paddr,
   input wire logic [CBCR_DATA_W-1:0] pwdata,
   input wire logic [CBCR_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Capture input and controls
   input wire logic [31:0] capture_position,
   input wire cbcr_ctrl_type ctrl
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access phase of any transfer
   wire logic acc = psel & penable;

   reset_ctrl_a: assert property ($rose(presetn) |-> ctrl.seq_clock_gen_on && ctrl.hf_on == 4'hF
      && ctrl.hf_level == {4{3'h6}}) else $error("ctrl not at reset values after reset");
   low_power_a: assert property (ctrl.low_power_request |->
      ctrl.hf_active == 4'h0 && !ctrl.seq_clock_gen_on) else $error("outputs active in low power");
   active_a: assert property (!ctrl.low_power_request |->
      ctrl.hf_active == ctrl.hf_on) else $error("active outputs differ from enables");
   zero_wait_a: assert property (acc |-> pready) else $error("access phase not answered");
   misalign_a: assert property (acc && !pwrite && paddr[1:0] != 2'h0 |->
      pslverr && prdata == 32'h0000_0000) else $error("misaligned read not refused");
   mapped_ok_a: assert property (acc && paddr == 12'h168 |-> !pslverr) else $error("last location refused");
   upper_zero_a: assert property (acc && !pwrite |->
      prdata[31:16] == 16'h0000) else $error("upper read half not zero");
   power_ro_a: assert property (acc && !pwrite && paddr == 12'h000 |->
      prdata[15:3] == 13'h0000) else $error("read-only power bits not zero");
   enable_write_a: assert property (acc && pwrite && paddr == 12'h00C |=>
      ctrl.hf_on == $past(pwdata[15:12])) else $error("enable write not applied next cycle");
   level_write_a: assert property (acc && pwrite && paddr == 12'h014 |=>
      ctrl.hf_level[3] == $past(pwdata[5:3]) && ctrl.hf_level[2] == $past(pwdata[2:0]))
      else $error("high level pair not applied");
   hold_ctrl_a: assert property (!(acc && pwrite) |=> $stable(ctrl)) else $error("ctrl moved without write");
endmodule

// [test/testbench.sv]
// Self-checking bench for the register bank, driven through the host model.
// Assumes a 100 MHz pclk and no other clock.
`timescale 1ns/1ps
module testbench
   import cbcr_pkg::*;
;
   typedef struct packed {
      logic [11:0] addr;
      logic [15:0] wdata;
      logic [31:0] rdata;
      logic err;
   } cbcr_row_type;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [31:0] capture_position = 32'hA5C3_1E0F;
   logic err;
   cbcr_ctrl_type ctrl;
   int bad_count = 0;
   int checks = 0;
   int cycles = 0;
   logic [11:0] rst_addr [5] = '{12'h000, 12'h008, 12'h00C, 12'h010, 12'h014};
   logic [15:0] rst_val [5] = '{16'h0000, 16'h0223, 16'hF0FE, 16'h36FF, 16'h36F6};
   // Write, then read back; refused rows expect an error and zero data
   cbcr_row_type rows [12] = '{
      '{12'h008, 16'h0203, 32'h0203, 1'b0}, '{12'h00C, 16'h50FE, 32'h50FE, 1'b0},
      '{12'h010, 16'h0AFF, 32'h0AFF, 1'b0}, '{12'h014, 16'h36F9, 32'h36F9, 1'b0},
      '{12'h000, 16'hFFFF, 32'h0007, 1'b0}, '{12'h000, 16'h0000, 32'h0000, 1'b0},
      '{12'h02C, 16'hFFFF, 32'h1E0F, 1'b0}, '{12'h030, 16'h0000, 32'hA5C3, 1'b0},
      '{12'h168, 16'h0060, 32'h0060, 1'b0}, '{12'h004, 16'h1234, 32'h0000, 1'b1},
      '{12'h16C, 16'h1234, 32'h0000, 1'b1}, '{12'h001, 16'h1234, 32'h0000, 1'b1}};

   cbcr_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .capture_position, .ctrl);
   cbcr_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

   // Clock and hang guard; about 120 cycles are expected
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence: reset values, table, low power, second reset
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         u_host.xfer(1'b0, rst_addr[i], 16'h0000, rd, err);
         check("reset word", rd, {16'h0000, rst_val[i]});
      end
      check("reset ctrl", {10'h000, ctrl}, {10'h000, 1'b0, 1'b1, 4'hF, 4'hF, 12'hDB6});
      $display("test reset done");
      u_host.init();
      for (int i = 0; i < 12; i++) begin
         u_host.xfer(1'b1, rows[i].addr, rows[i].wdata, rd, err);
         check("write error", {31'h0, err}, {31'h0, rows[i].err});
         u_host.xfer(1'b0, rows[i].addr, 16'h0000, rd, err);
         check("readback", rd, rows[i].rdata);
         check("read error", {31'h0, err}, {31'h0, rows[i].err});
      end
      @(negedge pclk);
      check("ctrl fields", {10'h000, ctrl}, {10'h000, 1'b0, 1'b0, 4'h5, 4'h5, 12'hE4A});
      $display("test table done");
      // Low power gates the outputs but keeps every stored word
      u_host.xfer(1'b1, 12'h000, 16'h0004, rd, err);
      @(negedge pclk);
      check("low power ctrl", {10'h000, ctrl}, {10'h000, 1'b1, 1'b0, 4'h5, 4'h0, 12'hE4A});
      u_host.xfer(1'b0, 12'h00C, 16'h0000, rd, err);
      check("kept enables", rd, 32'h0000_50FE);
      u_host.xfer(1'b1, 12'h000, 16'h0000, rd, err);
      $display("test low power done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      u_host.xfer(1'b0, 12'h00C, 16'h0000, rd, err);
      check("second reset", rd, 32'h0000_F0FE);
      $display("test second reset done");
      print_verdict();
   end
endmodule

bind cbcr_regs cbcr_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .capture_position, .ctrl);
